// ### dv/overlay_pixel_unpacker_tb.sv
`timescale 1ns/10ps
`include "overlay_unpacker_map.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected %0t got %h want %h", $time, a, b); end end
module overlay_pixel_unpacker_tb;
  localparam W = 32'h96E1_D2C3;
  reg clk_in = 1'b0, resetn_in = 1'b0, req = 1'b0, fs = 1'b0, wv = 1'b0, cw = 1'b0, slow = 1'b0;
  reg [2:0] fmt = 3'h0;
  reg [7:0] ca = 8'h00;
  reg [11:0] cd = 12'h000;
  reg [31:0] wd = 32'h0000_0000;
  wire pend, wr, pv, pr;
  wire [2:0] af;
  wire [11:0] rgb;
  int err_count = 0, num_checks = 0;
  overlay_pixel_unpacker dut (.clk_in(clk_in), .resetn_in(resetn_in), .attr_format_in(fmt),
    .attribute_update_request_in(req), .frame_start_in(fs), .attribute_update_pending_out(pend),
    .active_format_out(af), .clut_wr_en_in(cw), .clut_wr_addr_in(ca), .clut_wr_data_in(cd),
    .word_valid_in(wv), .word_data_in(wd), .word_ready_out(wr), .pixel_valid_out(pv),
    .pixel_rgb_out(rgb), .pixel_ready_in(pr));
  pixel_sink sink (.clk_in(clk_in), .slow_in(slow), .valid_in(pv), .rgb_in(rgb), .ready_out(pr));
  initial forever #25 clk_in = ~clk_in;
  task close_out;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Attributes first, then request, then poll pending
  task update(input [2:0] f);
    @(posedge clk_in) fmt <= f;
    @(posedge clk_in) req <= 1'b1;
    @(posedge clk_in) req <= 1'b0;
    repeat (3) @(posedge clk_in);
    @(negedge clk_in) `CHK(pend, 1'b1)
    @(posedge clk_in) fs <= 1'b1;
    @(posedge clk_in) fs <= 1'b0;
    @(negedge clk_in) `CHK(pend, 1'b0)
    `CHK(af, f)
  endtask
  task send(input [31:0] w);
    @(posedge clk_in) wv <= 1'b1;
    wd <= w;
    @(negedge clk_in);
    repeat (200) if (!wr) @(negedge clk_in);
    `CHK(wr, 1'b1)
    @(posedge clk_in) wv <= 1'b0;
  endtask
  // Palette formats map through the loaded table, 12 bpp drops the top nibble
  function [11:0] pix(input [2:0] f, input [31:0] w, input int k);
    int b;
    b = (f == `FMT_12BPP) ? 16 : 1 << f;
    w = w >> (k * b);
    pix = (f == `FMT_12BPP) ? w[11:0] : {4'h5, w[7:0] & 8'((1 << b) - 1)};
  endfunction
  // Two words back to back, sink stalling in odd formats
  task format_run(input [2:0] f);
    int n;
    update(f);
    n = (f == `FMT_12BPP) ? 2 : 32 >> f;
    sink.got.delete();
    @(posedge clk_in) slow <= f[0];
    send(W);
    send(~W);
    repeat (300) if (sink.got.size() < 2 * n) @(posedge clk_in);
    // Linger so that a repeated pixel would still show in the count
    repeat (8) @(posedge clk_in);
    `CHK(sink.got.size(), 2 * n)
    for (int k = 0; k < 2 * n; k++) `CHK(sink.got[k], pix(f, k < n ? W : ~W, k % n))
  endtask
  initial begin
    repeat (12) @(posedge clk_in);
    resetn_in <= 1'b1;
    for (int i = 0; i < 256; i++) begin
      @(posedge clk_in) cw <= 1'b1;
      ca <= i[7:0];
      cd <= {4'h5, i[7:0]};
    end
    @(posedge clk_in) cw <= 1'b0;
    for (int f = 0; f < 5; f++) format_run(f[2:0]);
    close_out;
  end
  // Run needs under 1000 cycles; allow ten times that
  initial begin
    #500000;
    err_count++;
    close_out;
  end
endmodule // overlay_pixel_unpacker_tb
bind overlay_pixel_unpacker unpacker_chk chk (.clk_in(clk_in), .resetn_in(resetn_in),
  .attr_format_in(attr_format_in), .attribute_update_request_in(attribute_update_request_in),
  .frame_start_in(frame_start_in), .attribute_update_pending_out(attribute_update_pending_out),
  .active_format_out(active_format_out), .word_valid_in(word_valid_in), .word_ready_out(word_ready_out),
  .pixel_valid_out(pixel_valid_out), .pixel_rgb_out(pixel_rgb_out), .pixel_ready_in(pixel_ready_in));

// ### dv/pixel_sink.sv
`timescale 1ns/10ps
module pixel_sink (
  input wire clk_in,
  input wire slow_in,
  input wire valid_in,
  input wire [11:0] rgb_in,
  output reg ready_out
);
  logic [11:0] got[$];
  // Slow mode stalls every other cycle to exercise the buffer
  always @(posedge clk_in) ready_out <= slow_in ? ~ready_out : 1'b1;
  // Capture at negedge, where handshake values are settled
  always @(negedge clk_in) if (valid_in && ready_out) got.push_back(rgb_in);
endmodule // pixel_sink

// ### dv/unpacker_chk.sv
`timescale 1ns/10ps
module unpacker_chk (
  input wire clk_in,
  input wire resetn_in,
  input wire [2:0] attr_format_in,
  input wire attribute_update_request_in,
  input wire frame_start_in,
  input wire attribute_update_pending_out,
  input wire [2:0] active_format_out,
  input wire word_valid_in,
  input wire word_ready_out,
  input wire pixel_valid_out,
  input wire [11:0] pixel_rgb_out,
  input wire pixel_ready_in
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  // Short aliases keep each property on few lines
  wire pend = attribute_update_pending_out;
  wire fs = frame_start_in;
  sequence s_take; word_valid_in && word_ready_out; endsequence
  sequence s_stall; pixel_valid_out && !pixel_ready_in; endsequence
  chk_pend_set: assert property (attribute_update_request_in && !fs |=> pend)
    else $error("pending not raised");
  chk_pend_hold: assert property (pend && !fs |=> pend)
    else $error("pending dropped early");
  chk_pend_clear: assert property (pend && fs |=> !pend && active_format_out == $past(attr_format_in))
    else $error("update not applied");
  chk_fmt_keep: assert property (!(pend && fs) |=> $stable(active_format_out))
    else $error("format changed unasked");
  chk_pend_cause: assert property ($rose(pend) |-> $past(attribute_update_request_in))
    else $error("pending without request");
  chk_pend_idle: assert property (!pend && !attribute_update_request_in |=> !pend)
    else $error("pending rose alone");
  chk_word_lat: assert property (s_take |=> !word_ready_out ##2 pixel_valid_out)
    else $error("first pixel late");
  chk_pix_hold: assert property (s_stall |=> pixel_valid_out && $stable(pixel_rgb_out))
    else $error("stalled pixel lost");
endmodule // unpacker_chk

// ### pkg/overlay_unpacker_map.vh
`ifndef OVERLAY_UNPACKER_MAP_VH
`define OVERLAY_UNPACKER_MAP_VH
// Pixel format codes
`define FMT_1BPP 3'h0
`define FMT_2BPP 3'h1
`define FMT_4BPP 3'h2
`define FMT_8BPP 3'h3
`define FMT_12BPP 3'h4
// Pixels per word, minus one, per format
`define LAST_1BPP 5'h1F
`define LAST_2BPP 5'h0F
`define LAST_4BPP 5'h07
`define LAST_8BPP 5'h03
`define LAST_12BPP 5'h01
// Colour lookup table geometry
`define CLUT_DEPTH 256
`define CLUT_AW 8
`define CLUT_DW 12
// Direct colour field positions within a halfword
`define BLUE_LSB 0
`define GREEN_LSB 4
`define RED_LSB 8
`endif

// ### src/clut_memory.v
`timescale 1ns/10ps
// Colour lookup table, one write port, registered read data
module clut_memory (
  input wire clk_in,
  input wire wr_en_in,
  input wire [7:0] wr_addr_in,
  input wire [11:0] wr_data_in,
  input wire [7:0] rd_addr_in,
  output reg [11:0] rd_data_out
);
  reg [11:0] mem [0:255];

  // No reset on the array; software loads it before use
  always @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_addr_in];
  end
endmodule // clut_memory

// ### src/overlay_pixel_unpacker.v
`timescale 1ns/10ps
`include "overlay_unpacker_map.vh"
// Overview of operation
// - Pending flag stays high after update request until new attributes apply, then clears.
// - 1 bpp: thirty-two pixels per word, pixel zero in bit zero.
// - 2 bpp: sixteen pixels per word, pixel zero in bits one to zero.
// - 4 bpp: eight pixels per word, pixel zero in bits three to zero.
// - 8 bpp: four byte pixels per word, pixel zero in lowest byte.
// - 12 bpp: two pixels per word, blue lowest nibble, top nibble ignored.
// - Palette formats index the lookup table and output the selected entry.
module overlay_pixel_unpacker (
  input wire clk_in,
  input wire resetn_in,
  // Attribute shadowing
  input wire [2:0] attr_format_in,
  input wire attribute_update_request_in,
  input wire frame_start_in,
  output reg attribute_update_pending_out,
  output reg [2:0] active_format_out,
  // Lookup table load port
  input wire clut_wr_en_in,
  input wire [7:0] clut_wr_addr_in,
  input wire [11:0] clut_wr_data_in,
  // Frame buffer words
  input wire word_valid_in,
  input wire [31:0] word_data_in,
  output wire word_ready_out,
  // Pixels toward display
  output wire pixel_valid_out,
  output wire [11:0] pixel_rgb_out,
  input wire pixel_ready_in
);
  // Word walker states, one-hot
  localparam ST_IDLE = 2'h1;
  localparam ST_BUSY = 2'h2;

  // Current word, its pixel counter and the format latched with it
  reg [1:0] state;
  reg [31:0] word;
  reg [4:0] index;
  reg [4:0] last_index;
  reg [2:0] fmt;
  // Pixel picked out of the word, as table index or direct colour
  reg [7:0] clut_index;
  reg [11:0] direct_rgb;
  // Stage 1: address issued to table; stage 2: data in buffer
  reg s1_valid;
  reg s1_direct;
  reg [11:0] s1_rgb;
  wire [11:0] clut_data;
  // Two-entry output buffer
  reg [11:0] buf_data0;
  reg [11:0] buf_data1;
  reg [1:0] buf_count;
  wire buf_push;
  wire buf_pop;
  // Buffer room and issue strobe
  wire room;
  wire emit;
  wire [11:0] push_data;

  // Shadowed attributes apply at the next frame start; pending shows the wait
  // Applying only at a frame boundary keeps one frame in one format
  // A request that meets the apply cycle is lost; the user must request again
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      attribute_update_pending_out <= 1'h0;
      active_format_out <= `FMT_1BPP;
    end else if (attribute_update_pending_out && frame_start_in) begin
      active_format_out <= attr_format_in;
      attribute_update_pending_out <= 1'h0;
    end else if (attribute_update_request_in) begin
      attribute_update_pending_out <= 1'h1;
    end
  end

  // Last pixel index of a word for each format
  // Codes outside the five formats fall back to the 1 bpp walk
  always @* begin
    case (fmt)
      `FMT_1BPP: last_index = `LAST_1BPP;
      `FMT_2BPP: last_index = `LAST_2BPP;
      `FMT_4BPP: last_index = `LAST_4BPP;
      `FMT_8BPP: last_index = `LAST_8BPP;
      `FMT_12BPP: last_index = `LAST_12BPP;
      default: last_index = `LAST_1BPP;
    endcase
  end

  // Pixel extraction, little endian, pixel zero in the low bits
  always @* begin
    clut_index = 8'h00;
    direct_rgb = 12'h000;
    case (fmt)
      // Palette formats: the lowest pixel sits in the lowest bits
      `FMT_1BPP: clut_index = {7'h00, word[index]};
      `FMT_2BPP: clut_index = {6'h00, word[{index[3:0], 1'h0} +: 2]};
      `FMT_4BPP: clut_index = {4'h0, word[{index[2:0], 2'h0} +: 4]};
      `FMT_8BPP: clut_index = word[{index[1:0], 3'h0} +: 8];
      `FMT_12BPP: begin
        // Top nibble of each halfword is dropped
        direct_rgb[3:0] = word[{index[0], 4'h0} + `BLUE_LSB +: 4];
        direct_rgb[7:4] = word[{index[0], 4'h0} + `GREEN_LSB +: 4];
        direct_rgb[11:8] = word[{index[0], 4'h0} + `RED_LSB +: 4];
      end
      default: clut_index = 8'h00;
    endcase
  end

  // Room for one more pixel, counting the one still in the table read
  // Waiting on the in-flight pixel costs a cycle after a stall but keeps the buffer at two
  // Issue also waits while the receiver stalls with the buffer full
  assign room = (buf_count == 2'h0) || (buf_count == 2'h1 && !s1_valid) || buf_pop;
  // One pixel per cycle while the buffer has room for what is in flight
  assign emit = (state == ST_BUSY) && room;
  // Ready only between words, so each word costs one idle cycle
  assign word_ready_out = (state == ST_IDLE);

  // Walk the word's pixels in order, then take the next word
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      state <= ST_IDLE;
      word <= 32'h00000000;
      index <= 5'h00;
      fmt <= `FMT_1BPP;
    end else begin
      case (state)
        ST_IDLE: begin
          // Format is latched per word so an update never splits a word
          if (word_valid_in) begin
            word <= word_data_in;
            fmt <= active_format_out;
            index <= 5'h00;
            state <= ST_BUSY;
          end
        end
        ST_BUSY: begin
          if (emit) begin
            // Leave once the last pixel of the word has been issued
            if (index == last_index) begin
              state <= ST_IDLE;
            end else begin
              index <= index + 5'h01;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Table read data arrive one cycle after the index
  clut_memory u_clut (
    .clk_in(clk_in),
    .wr_en_in(clut_wr_en_in),
    .wr_addr_in(clut_wr_addr_in),
    .wr_data_in(clut_wr_data_in),
    .rd_addr_in(clut_index),
    .rd_data_out(clut_data)
  );

  // Match direct colour to the table's one-cycle read latency
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      s1_valid <= 1'h0;
      s1_direct <= 1'h0;
      s1_rgb <= 12'h000;
    end else begin
      // Valid and the direct flag travel with the pixel they belong to
      s1_valid <= emit;
      s1_direct <= (fmt == `FMT_12BPP);
      s1_rgb <= direct_rgb;
    end
  end

  // Palette pixels take the table entry; direct pixels bypass the table
  assign push_data = s1_direct ? s1_rgb : clut_data;
  // Buffer handshake on both sides
  assign buf_push = s1_valid;
  assign buf_pop = (buf_count != 2'h0) && pixel_ready_in;
  assign pixel_valid_out = (buf_count != 2'h0);
  // Pixel data leave straight from the head flip-flop
  assign pixel_rgb_out = buf_data0;

  // Two-entry buffer; a receiver stall never drops a pixel
  always @(posedge clk_in) begin
    if (!resetn_in) begin
      buf_count <= 2'h0;
      buf_data0 <= 12'h000;
      buf_data1 <= 12'h000;
    end else begin
      case ({buf_push, buf_pop})
        // Push only: fill the first free entry
        2'h2: begin
          if (buf_count == 2'h0) begin
            buf_data0 <= push_data;
          end else begin
            buf_data1 <= push_data;
          end
          buf_count <= buf_count + 2'h1;
        end
        // Pop only: the second entry moves to the head
        2'h1: begin
          buf_data0 <= buf_data1;
          buf_count <= buf_count - 2'h1;
        end
        // Both: head leaves, the new pixel joins behind what remains
        2'h3: begin
          if (buf_count == 2'h1) begin
            buf_data0 <= push_data;
          end else begin
            buf_data0 <= buf_data1;
            buf_data1 <= push_data;
          end
        end
        default: buf_count <= buf_count;
      endcase
    end
  end
endmodule // overlay_pixel_unpacker
